// ### src/flash_bus_host.sv
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_bus_host
  import flash_host_pkg::*;
#(
  parameter int ADDR_W  = 19,
  parameter int CLK_NS  = 100
)(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [2:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [15:0]       req_wdata,
  input  wire logic              req_byte_mode,
  input  wire logic              req_boot,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_rdata,
  output logic                   chip_sel_n,
  output logic                   out_en_n,
  output logic                   write_en_n,
  output logic                   width_sel_n,
  output logic [ADDR_W-1:0]      addr,
  output logic                   ident_enable,
  output logic                   prog_supply_en,
  output logic                   boot_unlock_en,
  output logic                   reset_powerdown_n,
  output logic [15:0]            dq_out,
  output logic [15:0]            dq_oe_n,
  input  wire logic [15:0]       dq_in
);
  localparam int ACC_CYC = (`ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB_CYC = (`STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC = (`RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W   = 8;

  host_state_t        state_reg, state_next;
  logic [2:0]         op_reg;
  logic [ADDR_W-1:0]  addr_reg;
  logic [15:0]        wdata_reg;
  logic               byte_reg, boot_reg, second_reg;
  logic [CNT_W-1:0]   cnt_reg;

  wire is_read   = (op_reg == `OP_READ) || (op_reg == `OP_IDENT);
  wire two_cycle = (op_reg == `OP_ERASE) || (op_reg == `OP_PROGRAM);
  wire [CNT_W-1:0] strobe_len = is_read ? CNT_W'(ACC_CYC) : CNT_W'(STB_CYC);
  wire cnt_done  = (cnt_reg == '0);
  // supply stays on through the recovery gap, so it is still there as the strobe rises
  wire active    = (state_reg != ST_IDLE);
  // outputs are registered from state_next, so on the take edge they follow the
  // incoming request and not the one that has just finished
  wire [2:0] op_cur   = (state_reg == ST_IDLE) ? req_op : op_reg;
  wire       byte_cur = (state_reg == ST_IDLE) ? req_byte_mode : byte_reg;
  wire       a0_cur   = (state_reg == ST_IDLE) ? req_addr[0] : addr_reg[0];
  wire       read_cur = (op_cur == `OP_READ) || (op_cur == `OP_IDENT);
  wire write_next = (state_next == ST_SETUP) || ((state_next == ST_CYCLE) && !read_cur);
  wire read_next  = (state_next == ST_CYCLE) && read_cur;
  wire prog_next  = (state_next == ST_CYCLE) && (op_cur == `OP_PROGRAM);
  // command byte rides only on the low byte; upper lanes left at zero
  wire [7:0] setup_cmd = (op_cur == `OP_ERASE) ? `CMD_ERASE_SETUP : `CMD_WRITE_SETUP;
  wire [7:0] final_cmd = (op_cur == `OP_ERASE) ? `CMD_ERASE_CONFIRM : `CMD_READ_ARRAY;
  // byte write: low byte carries data, top pin carries the lowest address bit
  wire [15:0] prog_word = byte_reg ? {addr_reg[0], 7'h00, wdata_reg[7:0]} : wdata_reg;
  wire [15:0] cmd_word  = {8'h00, (state_next == ST_SETUP) ? setup_cmd : final_cmd};
  // byte read: the host still owns the top pin, which is the lowest address bit there
  wire        byte_rd_pin = read_next && byte_cur;
  wire [15:0] rd_word     = {a0_cur, 15'h0000};
  wire [15:0] dq_next = read_next ? rd_word : (prog_next ? prog_word : cmd_word);
  wire [15:0] oe_next = write_next ? 16'h0000 : (byte_rd_pin ? 16'h7FFF : 16'hFFFF);
  wire [ADDR_W-1:0] out_addr = byte_reg ? (addr_reg >> 1) : addr_reg;
  wire [ADDR_W-1:0] id_addr  = {{(ADDR_W-1){1'b0}}, addr_reg[0]};
  wire [15:0] byte_rd = byte_reg ? {8'h00, dq_in[7:0]} : dq_in;

  assign req_ready = (state_reg == ST_IDLE);

  function automatic logic two_cycle_req(input logic [2:0] op);
    two_cycle_req = (op == `OP_ERASE) || (op == `OP_PROGRAM);
  endfunction

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (req_valid) state_next = two_cycle_req(req_op) ? ST_SETUP : ST_CYCLE;
      ST_SETUP: if (cnt_done) state_next = ST_GAP;
      ST_GAP:   if (cnt_done) state_next = second_reg ? ST_DONE : ST_CYCLE;
      ST_CYCLE: if (cnt_done) state_next = ST_GAP;
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg  <= ST_IDLE;
      op_reg     <= `OP_READ;
      addr_reg   <= '0;
      wdata_reg  <= 16'h0000;
      byte_reg   <= 1'b0;
      boot_reg   <= 1'b0;
      second_reg <= 1'b0;
      cnt_reg    <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && req_valid)
      begin
        op_reg     <= req_op;
        addr_reg   <= req_addr;
        wdata_reg  <= req_wdata;
        byte_reg   <= req_byte_mode;
        boot_reg   <= req_boot;
        second_reg <= 1'b0;
        cnt_reg    <= two_cycle_req(req_op) ? CNT_W'(STB_CYC - 1)
                    : ((req_op == `OP_READ || req_op == `OP_IDENT) ? CNT_W'(ACC_CYC - 1)
                    : CNT_W'(STB_CYC - 1));
      end
      else if (state_next != state_reg)
      begin
        if (state_reg == ST_CYCLE) second_reg <= 1'b1;
        cnt_reg <= (state_next == ST_GAP) ? CNT_W'(REC_CYC - 1) : strobe_len - 1'b1;
      end
      else if (!cnt_done)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // bus outputs registered so strobes are glitch free toward the part
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_sel_n <= 1'b1;
      out_en_n   <= 1'b1;
      write_en_n <= 1'b1;
      dq_oe_n    <= 16'hFFFF;
      dq_out     <= 16'h0000;
      rsp_valid  <= 1'b0;
      rsp_rdata  <= 16'h0000;
    end
    else
    begin
      chip_sel_n <= !(state_next == ST_SETUP || state_next == ST_CYCLE);
      out_en_n   <= !read_next;
      write_en_n <= !write_next;
      dq_oe_n    <= oe_next;
      dq_out     <= dq_next;
      rsp_valid  <= (state_reg == ST_CYCLE) && cnt_done && is_read;
      if ((state_reg == ST_CYCLE) && cnt_done && is_read)
        rsp_rdata <= byte_rd;
    end
  end

  // supply and unlock held across whole sequence until the part settles
  assign prog_supply_en   = active && two_cycle;
  assign boot_unlock_en   = active && two_cycle && boot_reg;
  assign ident_enable     = (op_reg == `OP_IDENT) && (state_reg != ST_IDLE);
  assign reset_powerdown_n = rst_n;
  assign width_sel_n      = !byte_reg;
  assign addr             = (op_reg == `OP_IDENT) ? id_addr : out_addr;

  // bus outputs and state change on the same edge, so they are compared in step
  a_strobe_excl: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(!out_en_n && !write_en_n)) else $error("read and write strobes overlap");
  a_drive_on_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    !write_en_n |-> dq_oe_n == 16'h0000) else $error("write without driving data");
  a_float_on_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    !out_en_n |-> dq_oe_n == (width_sel_n ? 16'hFFFF : 16'h7FFF))
    else $error("host drives during read");
  a_byte_addr_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!out_en_n && !width_sel_n) |-> dq_out[15] == addr_reg[0])
    else $error("top pin does not carry the lowest address bit");
  a_cs_with_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!out_en_n || !write_en_n) |-> !chip_sel_n) else $error("strobe without select");
  a_boot_supply: assert property (@(posedge core_clk) disable iff (!rst_n)
    boot_unlock_en |-> prog_supply_en && boot_reg) else $error("unlock without supply");
  a_supply_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_ready |-> !prog_supply_en && !boot_unlock_en) else $error("supply on while idle");
  a_ready_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    rsp_valid |-> ##2 req_ready) else $error("answer not followed by ready");
  a_ident_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    ident_enable |-> addr[ADDR_W-1:1] == '0) else $error("identification address not clear");
  // two-cycle commands: setup strobe, one recovery cycle, then the second strobe
  sequence erase_setup_s;
    (state_reg == ST_SETUP) && (op_reg == `OP_ERASE) && !write_en_n
      && (dq_out[7:0] == `CMD_ERASE_SETUP);
  endsequence
  sequence write_setup_s;
    (state_reg == ST_SETUP) && (op_reg == `OP_PROGRAM) && !write_en_n
      && (dq_out[7:0] == `CMD_WRITE_SETUP);
  endsequence
  sequence second_strobe_s;
    !write_en_n && !chip_sel_n && prog_supply_en;
  endsequence
  a_erase_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    erase_setup_s ##1 write_en_n |=> second_strobe_s ##0 (dq_out[7:0] == `CMD_ERASE_CONFIRM))
    else $error("erase confirm does not follow setup");
  a_program_data: assert property (@(posedge core_clk) disable iff (!rst_n)
    write_setup_s ##1 write_en_n |=> second_strobe_s ##0 (dq_out == prog_word))
    else $error("program data does not follow setup");
  a_read_array_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == ST_CYCLE) && (op_reg == `OP_READ_ARRAY) |-> !write_en_n
      && (dq_out[7:0] == `CMD_READ_ARRAY)) else $error("array read command not issued");
endmodule

// ### include/flash_host_map.svh
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
`define CMD_ERASE_SETUP   8'h20
`define CMD_ERASE_CONFIRM 8'hD0
`define CMD_WRITE_SETUP   8'h40
`define CMD_WRITE_ALT     8'h10
`define CMD_READ_ARRAY    8'hFF
`define OP_READ           3'h0
`define OP_ERASE          3'h1
`define OP_PROGRAM        3'h2
`define OP_READ_ARRAY     3'h3
`define OP_IDENT          3'h4
`define ACCESS_NS         100
`define STROBE_NS         100
`define RECOVER_NS        100
`endif

// ### include/flash_host_pkg.sv
package flash_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_GAP,
    ST_CYCLE,
    ST_DONE
  } host_state_t;
endpackage

// ### testbench/flash_model.sv
`timescale 1ns/1ps
module flash_model #(
  parameter logic [15:0] MAN_ID = 16'h00A5, // arbitrary value
  parameter logic [15:0] DEV_ID = 16'h5A3C  // arbitrary value
)(
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        write_en_n,
  input  wire logic        width_sel_n,
  input  wire logic [18:0] addr,
  input  wire logic        ident_enable,
  input  wire logic        prog_supply_en,
  input  wire logic        boot_unlock_en,
  input  wire logic        reset_powerdown_n,
  input  wire logic [15:0] dq_out,
  input  wire logic [15:0] dq_oe_n,
  output logic      [15:0] dq_in
);
  logic [15:0] mem [0:524287];
  logic [1:0]  mode_reg = 0; // 0 array, 1 erase armed, 2 write armed, 3 status
  logic [15:0] wd;
  logic [18:0] wa;
  logic        wsel = 0;
  wire         ok = prog_supply_en && (wa >= 19'h02000 || boot_unlock_en);
  wire         drv = reset_powerdown_n && !chip_sel_n && !out_en_n && write_en_n;
  wire         hi = !width_sel_n && !dq_oe_n[15] && dq_out[15];
  wire  [15:0] q = ident_enable ? (addr[0] ? DEV_ID : MAN_ID)
                 : mode_reg == 3 ? 16'h0080 : mem[addr];
  initial foreach (mem[k]) mem[k] = 16'hFFFF;
  // undriven pins show the inverse so a stale value cannot pass
  always @*
    for (int i = 0; i < 16; i++)
      dq_in[i] = !dq_oe_n[i] ? dq_out[i] : (drv && (i < 8 || width_sel_n))
                 ? q[i + (i < 8 && hi ? 8 : 0)] : !q[i];
  // latched after the strobe falls to dodge the edge race with the host
  always @(negedge write_en_n)
  begin
    #1;
    wd = dq_out;
    wa = addr;
    // select may rise with the strobe, so the cycle type is taken while it is low
    wsel = !chip_sel_n && out_en_n;
  end
  always @(posedge write_en_n or negedge reset_powerdown_n)
    if (!reset_powerdown_n)
      mode_reg <= 0;
    else if (wsel && mode_reg == 2)
    begin
      if (ok && width_sel_n)
        mem[wa] = wd;
      else if (ok)
        mem[wa][wd[15]*8 +: 8] = wd[7:0];
      mode_reg <= 3;
    end
    else if (wsel && mode_reg == 1)
    begin
      if (ok && wd[7:0] == 8'hD0)
        for (int k = 0; k < 524288; k++)
          if ((k < 'h2000) == (wa < 19'h02000) && k >> 16 == wa >> 16) mem[k] = 16'hFFFF;
      mode_reg <= 3;
    end
    else if (wsel)
      mode_reg <= wd[7:0] == 8'h20 ? 1 : wd[7:0] inside {8'h10, 8'h40} ? 2
                : wd[7:0] == 8'hFF ? 0 : mode_reg;
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`include "flash_host_map.svh"
module tb_top;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        req_valid = 0;
  logic        req_byte_mode = 0;
  logic        req_boot = 0;
  logic [2:0]  req_op = 0;
  logic [18:0] req_addr = 0;
  logic [15:0] req_wdata = 0;
  logic [15:0] rd;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  wire         req_ready, rsp_valid, chip_sel_n, out_en_n, write_en_n, width_sel_n;
  wire         ident_enable, prog_supply_en, boot_unlock_en, reset_powerdown_n;
  wire  [18:0] addr;
  wire  [15:0] rsp_rdata, dq_out, dq_oe_n, dq_in;
  flash_bus_host dut (.core_clk, .rst_n, .req_valid, .req_ready, .req_op, .req_addr,
    .req_wdata, .req_byte_mode, .req_boot, .rsp_valid, .rsp_rdata, .chip_sel_n, .out_en_n,
    .write_en_n, .width_sel_n, .addr, .ident_enable, .prog_supply_en, .boot_unlock_en,
    .reset_powerdown_n, .dq_out, .dq_oe_n, .dq_in);
  flash_model model (.chip_sel_n, .out_en_n, .write_en_n, .width_sel_n, .addr,
    .ident_enable, .prog_supply_en, .boot_unlock_en, .reset_powerdown_n, .dq_out,
    .dq_oe_n, .dq_in);
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (++cyc > 20000)
    begin
      fails++;
      print_verdict();
    end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(input logic [2:0] o, input logic [18:0] a, input logic [15:0] d = 0);
    int n;
    n = 0;
    req_op = o;
    req_addr = a;
    req_wdata = d;
    req_boot = a < 19'h02000;
    req_valid = 1;
    // a request is taken only on an edge where the host is idle, so hold it until then
    while (req_ready !== 1'b1 && n++ < 40)
    begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    req_valid = 0;
    n = 0;
    while (!(o inside {0, 4} ? rsp_valid === 1'b1 : req_ready === 1'b1) && n++ < 40)
    begin
      @(posedge core_clk);
      #1;
    end
    rd = rsp_rdata;
  endtask
  task automatic t_main;
    op(`OP_PROGRAM, 19'h12345, 16'hA55A);
    op(`OP_PROGRAM, 19'h22222, 16'h1234);
    op(`OP_PROGRAM, 19'h00100, 16'hC3C3);
    op(`OP_READ, 19'h12345);
    chk("status", rd, 16'h0080);
    op(`OP_READ_ARRAY, 0);
    op(`OP_READ, 19'h12345);
    chk("word", rd, 16'hA55A);
    op(`OP_READ, 19'h00100);
    chk("boot", rd, 16'hC3C3);
    op(`OP_ERASE, 19'h10000);
    op(`OP_READ_ARRAY, 0);
    op(`OP_READ, 19'h12345);
    chk("erased", rd, 16'hFFFF);
    op(`OP_READ, 19'h22222);
    chk("kept", rd, 16'h1234);
    $display("array test done");
  endtask
  task automatic t_byte;
    req_byte_mode = 1;
    op(`OP_PROGRAM, 19'h44445, 16'h0077);
    op(`OP_READ_ARRAY, 0);
    op(`OP_READ, 19'h44445);
    chk("byte hi", {8'h00, rd[7:0]}, 16'h0077);
    op(`OP_READ, 19'h44444);
    chk("byte lo", {8'h00, rd[7:0]}, 16'h0034);
    req_byte_mode = 0;
    op(`OP_IDENT, 0);
    chk("maker", rd, 16'h00A5);
    op(`OP_IDENT, 1);
    chk("device", rd, 16'h5A3C);
    $display("byte and ident test done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1;
    chk("float", dq_oe_n, 16'hFFFF);
    t_main();
    t_byte();
    print_verdict();
  end
endmodule
